/* hw/irq_src_pkg.sv */
// Constants for the interrupt source, priority and pending block.
// Assumes a 32-bit AXI4-Lite register bus with full byte addresses.
package irq_src_pkg;

   // ----------------------------------------------------------------
   // Source numbering
   // ----------------------------------------------------------------
   localparam int NUM_SRC    = 186;
   localparam int NUM_WORDS  = 6;
   localparam int VEC_W      = NUM_WORDS * 32;
   localparam int PRIO_W     = 3;
   localparam int L2_CNT     = 4;
   localparam int DMA_CNT    = 8;
   localparam int PERIPH_CNT = 169;
   localparam int BEU_CNT    = 5;

   typedef logic [7:0]        id_t;
   typedef logic [PRIO_W-1:0] prio_t;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [31:0] PRIO_BASE  = 32'h0c00_0000;
   localparam logic [31:0] PEND_BASE  = 32'h0c00_1000;
   localparam logic [31:0] PEND_LAST  = 32'h0c00_1014;
   localparam logic [31:0] ENAB_BASE  = 32'h0c00_2000;
   localparam logic [31:0] THR_ADDR   = 32'h0c20_0000;
   localparam logic [31:0] CLAIM_ADDR = 32'h0c20_0004;

   // Field layout and reset values
   localparam int          PRIO_LSB   = 0;
   localparam int          THR_LSB    = 0;
   localparam int          PEND_LAST_USED = 26;
   localparam prio_t       PRIO_RST   = 3'h0;
   localparam prio_t       THR_RST    = 3'h0;
   localparam prio_t       PRIO_MAX   = 3'h7;
   localparam logic [VEC_W-1:0] VEC_RST = '0;

   // Bus responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : irq_src_pkg

/* hw/irq_source_priority_pending.sv */
// Interrupt source gateway, priority store, pending array and arbiter
// with one target's enables, threshold and claim/complete register.
// Assumes synchronous request inputs and an AXI4-Lite master.
`timescale 1ns/1ps

// Operation
// - Accept 186 independent global request inputs.
// - Requests are active-high levels, not edges.
// - Input line i is source identifier i+1; identifier zero means none.
// - One 32-bit priority word per source at base plus four times identifier.
// - Priority zero never interrupts; it disables the source.
// - Priorities rank from one lowest to seven highest.
// - Equal priorities: smallest identifier wins.
// - Priority in bits 2:0, upper bits ignore writes.
// - Pending flags packed into six readable 32-bit words.
// - Flag N sits at bit N mod 32 of word N div 32.
// - Bit zero of pending word zero always reads zero.
// - Pending flags read-only, reset to zero, first word at pending base.
// - Last pending word holds the top sources; bits above 186 reserved.
// - Enabling then claiming a source clears its pending flag.
// - Identifiers 1..4 carry the four level-two cache events.
// - Identifiers 13..181 come from the outside peripheral vector.
// - Identifiers 182..186 carry bus error units of harts 0..4.
// - Per-target enable bit per source; source zero enable fixed zero.
// - Sources at or below threshold do not interrupt; seven masks all.
// - Claim returns best pending enabled identifier or zero, clearing it.
module irq_source_priority_pending
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [3:0]  l2_cache_irq,
   input  wire logic [7:0]  dma_irq,
   input  wire logic [168:0] periph_irq,
   input  wire logic [4:0]  bus_error_irq,
   input  wire logic [31:0] awaddr,
   input  wire logic        awvalid,
   output      logic        awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output      logic        wready,
   output      logic [1:0]  bresp,
   output      logic        bvalid,
   input  wire logic        bready,
   input  wire logic [31:0] araddr,
   input  wire logic        arvalid,
   output      logic        arready,
   output      logic [31:0] rdata,
   output      logic [1:0]  rresp,
   output      logic        rvalid,
   input  wire logic        rready,
   output      logic        irq_request
);

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   function automatic logic is_prio(input logic [31:0] a);
      is_prio = (a[31:10] == irq_src_pkg::PRIO_BASE[31:10])
             && (a[9:2] != 8'h00)
             && (a[9:2] <= irq_src_pkg::id_t'(irq_src_pkg::NUM_SRC));
   endfunction : is_prio

   function automatic logic is_pend(input logic [31:0] a);
      is_pend = (a[31:5] == irq_src_pkg::PEND_BASE[31:5])
             && (a[4:2] <= irq_src_pkg::PEND_LAST[4:2]);
   endfunction : is_pend

   function automatic logic is_enab(input logic [31:0] a);
      is_enab = (a[31:5] == irq_src_pkg::ENAB_BASE[31:5])
             && (a[4:2] <= irq_src_pkg::PEND_LAST[4:2]);
   endfunction : is_enab

   function automatic logic is_thr(input logic [31:0] a);
      is_thr = (a[31:2] == irq_src_pkg::THR_ADDR[31:2]);
   endfunction : is_thr

   function automatic logic is_claim(input logic [31:0] a);
      is_claim = (a[31:2] == irq_src_pkg::CLAIM_ADDR[31:2]);
   endfunction : is_claim

   function automatic logic is_mapped(input logic [31:0] a);
      is_mapped = is_prio(a) || is_pend(a) || is_enab(a)
               || is_thr(a) || is_claim(a);
   endfunction : is_mapped

   // Bits of a packed word that stand for real sources
   function automatic logic [31:0] word_mask(input logic [2:0] k);
      logic [31:0] m;
      m = 32'hffff_ffff;
      if (k == 3'h0)
      begin
         m[0] = 1'b0;
      end
      if (k == irq_src_pkg::PEND_LAST[4:2])
      begin
         m = 32'h07ff_ffff;
      end
      word_mask = m;
   endfunction : word_mask

   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  be);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = r;
   endfunction : merge

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [irq_src_pkg::NUM_SRC:0]     src_vec;
   logic [irq_src_pkg::NUM_SRC:0]     pending;
   logic [irq_src_pkg::NUM_SRC:0]     in_service;
   logic [irq_src_pkg::VEC_W-1:0]     enab;
   logic [irq_src_pkg::VEC_W-1:0]     pend_vec;
   irq_src_pkg::prio_t                prio [1:irq_src_pkg::NUM_SRC];
   irq_src_pkg::prio_t                threshold;
   irq_src_pkg::id_t                  best_id;
   irq_src_pkg::prio_t                best_prio;
   irq_src_pkg::id_t                  next_best_id;
   irq_src_pkg::prio_t                next_best_prio;
   logic                              aw_held;
   logic                              w_held;
   logic [31:0]                       aw_addr;
   logic [31:0]                       w_data;
   logic [3:0]                        w_strb;
   logic                              aw_take;
   logic                              w_take;
   logic                              ar_take;
   logic                              write_do;
   logic                              next_aw_held;
   logic                              next_w_held;
   logic                              next_rvalid;
   logic                              claim_fire;
   logic                              complete_ok;
   irq_src_pkg::id_t                  complete_id;
   logic [31:0]                       next_rdata;
   logic [2:0]                        rd_pend_word;
   logic [irq_src_pkg::NUM_SRC:0]     claim_mask;

   // Line i of the concatenation lands at identifier i+1; bit 0 is idle
   assign src_vec = {bus_error_irq, periph_irq, dma_irq,
                     l2_cache_irq, 1'b0};
   assign pend_vec = {{(irq_src_pkg::VEC_W - irq_src_pkg::NUM_SRC - 1)
                       {1'b0}}, pending};
   // One-hot copy of the source being claimed, full width of the array
   assign claim_mask = claim_fire
                       ? ({{irq_src_pkg::NUM_SRC{1'b0}}, 1'b1} << best_id)
                       : '0;

   // ----------------------------------------------------------------
   // Bus handshakes
   // ----------------------------------------------------------------
   assign aw_take      = awvalid && awready;
   assign w_take       = wvalid && wready;
   assign ar_take      = arvalid && arready;
   assign write_do     = aw_held && w_held && !bvalid;
   assign next_aw_held = (aw_held || aw_take) && !write_do;
   assign next_w_held  = (w_held || w_take) && !write_do;
   assign next_rvalid  = ar_take || (rvalid && !rready);
   // Claim reads best_id, which trails the pending array by one cycle;
   // arready stays low while rvalid, so two claims are never that close
   assign claim_fire   = ar_take && is_claim(araddr)
                      && (best_id != 8'h00);
   assign complete_id  = w_data[7:0];
   assign complete_ok  = write_do && is_claim(aw_addr)
                      && (w_data[31:8] == 24'h000000)
                      && (complete_id != 8'h00)
                      && (complete_id <= irq_src_pkg::id_t'(irq_src_pkg::NUM_SRC))
                      && enab[complete_id];

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_addr <= 32'h0000_0000;
         w_data  <= 32'h0000_0000;
         w_strb  <= 4'h0;
      end
      else
      begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         awready <= !next_aw_held;
         wready  <= !next_w_held;
         if (aw_take)
         begin
            aw_addr <= awaddr;
         end
         if (w_take)
         begin
            w_data <= wdata;
            w_strb <= wstrb;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid <= 1'b0;
         bresp  <= irq_src_pkg::RESP_OKAY;
      end
      else if (write_do)
      begin
         bvalid <= 1'b1;
         bresp  <= is_mapped(aw_addr) ? irq_src_pkg::RESP_OKAY
                                      : irq_src_pkg::RESP_SLVERR;
      end
      else if (bready)
      begin
         bvalid <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Register writes
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         for (int i = 1; i <= irq_src_pkg::NUM_SRC; i++)
         begin
            prio[i] <= irq_src_pkg::PRIO_RST;
         end
      end
      else if (write_do && is_prio(aw_addr) && w_strb[0])
      begin
         prio[aw_addr[9:2]] <= w_data[2:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enab <= irq_src_pkg::VEC_RST;
      end
      else if (write_do && is_enab(aw_addr))
      begin
         enab[aw_addr[4:2]*32 +: 32] <=
            merge(enab[aw_addr[4:2]*32 +: 32], w_data, w_strb)
            & word_mask(aw_addr[4:2]);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         threshold <= irq_src_pkg::THR_RST;
      end
      else if (write_do && is_thr(aw_addr) && w_strb[0])
      begin
         threshold <= w_data[2:0];
      end
   end

   // ----------------------------------------------------------------
   // Gateway and pending array
   // ----------------------------------------------------------------
   // A claim hands the source to software; its level is ignored until
   // completion so one held level gives exactly one claim per service
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         pending    <= '0;
         in_service <= '0;
      end
      else
      begin
         for (int i = 1; i <= irq_src_pkg::NUM_SRC; i++)
         begin
            if (claim_fire && (best_id == irq_src_pkg::id_t'(i)))
            begin
               pending[i]    <= 1'b0;
               in_service[i] <= 1'b1;
            end
            else
            begin
               if (src_vec[i] && !in_service[i])
               begin
                  pending[i] <= 1'b1;
               end
               if (complete_ok && (complete_id == irq_src_pkg::id_t'(i)))
               begin
                  in_service[i] <= 1'b0;
               end
            end
         end
         pending[0]    <= 1'b0;
         in_service[0] <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Arbiter
   // ----------------------------------------------------------------
   // Strict greater-than scanning upward keeps the lowest identifier on
   // a tie and never selects a priority of zero
   always_comb
   begin
      next_best_id   = 8'h00;
      next_best_prio = 3'h0;
      for (int i = 1; i <= irq_src_pkg::NUM_SRC; i++)
      begin
         if (pending[i] && enab[i] && (prio[i] > next_best_prio))
         begin
            next_best_id   = irq_src_pkg::id_t'(i);
            next_best_prio = prio[i];
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         best_id     <= 8'h00;
         best_prio   <= 3'h0;
         irq_request <= 1'b0;
      end
      else
      begin
         best_id     <= next_best_id;
         best_prio   <= next_best_prio;
         irq_request <= (next_best_prio > threshold);
      end
   end

   // ----------------------------------------------------------------
   // Register reads
   // ----------------------------------------------------------------
   always_comb
   begin
      next_rdata = 32'h0000_0000;
      if (is_prio(araddr))
      begin
         next_rdata[2:0] = prio[araddr[9:2]];
      end
      else if (is_pend(araddr))
      begin
         next_rdata = pend_vec[araddr[4:2]*32 +: 32];
      end
      else if (is_enab(araddr))
      begin
         next_rdata = enab[araddr[4:2]*32 +: 32];
      end
      else if (is_thr(araddr))
      begin
         next_rdata[2:0] = threshold;
      end
      else if (is_claim(araddr))
      begin
         next_rdata[7:0] = best_id;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid       <= 1'b0;
         arready      <= 1'b0;
         rdata        <= 32'h0000_0000;
         rresp        <= irq_src_pkg::RESP_OKAY;
         rd_pend_word <= 3'h7;
      end
      else
      begin
         rvalid  <= next_rvalid;
         arready <= !next_rvalid;
         if (ar_take)
         begin
            rdata        <= next_rdata;
            rresp        <= is_mapped(araddr) ? irq_src_pkg::RESP_OKAY
                                              : irq_src_pkg::RESP_SLVERR;
            rd_pend_word <= is_pend(araddr) ? araddr[4:2] : 3'h7;
         end
      end
   end

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_level_sets_flag: assert property (
      1'b1 |=> ((pending & $past(src_vec & ~in_service & ~claim_mask))
                == $past(src_vec & ~in_service & ~claim_mask)))
      else $error("raised input did not set its pending flag");

   a_zero_prio_quiet: assert property (
      (best_prio == 3'h0) |-> (!irq_request && best_id == 8'h00))
      else $error("priority zero presented as interrupt");

   a_thresh_masks_all: assert property (
      (threshold == irq_src_pkg::PRIO_MAX) |=> !irq_request)
      else $error("threshold seven did not mask request");

   a_best_is_valid: assert property (
      (best_id != 8'h00) |-> (prio[best_id] == best_prio
                              && best_prio != 3'h0))
      else $error("best priority does not match its source");

   a_claim_clears: assert property (
      claim_fire |=> (!pending[$past(best_id)]
                      && in_service[$past(best_id)]))
      else $error("claim did not clear pending flag");

   a_claim_returns: assert property (
      (ar_take && is_claim(araddr))
      |=> (rvalid && rdata == {24'h000000, $past(best_id)}))
      else $error("claim read returned wrong identifier");

   a_pend_bit0_zero: assert property (
      (rvalid && rd_pend_word == 3'h0) |-> (rdata[0] == 1'b0))
      else $error("pending bit zero read as one");

   a_pend_last_resv: assert property (
      (rvalid && rd_pend_word == 3'h5) |-> (rdata[31:27] == 5'h00))
      else $error("reserved pending bits read nonzero");

   a_complete_frees: assert property (
      (complete_ok && !claim_fire) |=> !in_service[$past(complete_id)])
      else $error("completion did not release source");

   a_prio_write: assert property (
      (write_do && is_prio(aw_addr) && w_strb[0])
      |=> (prio[$past(aw_addr[9:2])] == $past(w_data[2:0])))
      else $error("priority write not stored");

endmodule : irq_source_priority_pending

/* dv/irq_source_model.sv */
// Model of the units that raise global requests into the block.
// Assumes the bench changes one line at a time through raise or drop.
`timescale 1ns/1ps

module irq_source_model
(
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic [7:0]   line_idx,
   input  wire logic         raise,
   input  wire logic         drop,
   output      logic [3:0]   l2_cache_irq,
   output      logic [7:0]   dma_irq,
   output      logic [168:0] periph_irq,
   output      logic [4:0]   bus_error_irq
);
   logic [185:0] level;

   // Lines never raised stay low, like unused inputs tied off
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         level <= '0;
      else if (raise)
         level[line_idx] <= 1'b1;
      else if (drop)
         level[line_idx] <= 1'b0;
   end

   assign l2_cache_irq  = level[3:0];
   assign dma_irq       = level[11:4];
   assign periph_irq    = level[180:12];
   assign bus_error_irq = level[185:181];
endmodule : irq_source_model

/* dv/irq_source_priority_pending_bench.sv */
// Self-checking bench for the source, priority and pending block.
// Assumes the request model irq_source_model and an AXI4-Lite master.
`timescale 1ns/1ps

module irq_source_priority_pending_bench;
   logic         aclk, aresetn, raise, drop;
   logic [31:0]  awaddr, wdata, araddr, rdata, rd;
   logic         awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready, irq_request;
   logic [1:0]   bresp, rresp, rs;
   logic [3:0]   wstrb, l2_cache_irq;
   logic [7:0]   dma_irq, line_idx;
   logic [168:0] periph_irq;
   logic [4:0]   bus_error_irq;
   logic [31:0]  en[6], pend[6];
   int           failures, total_checks, cycles;
   int           ids[8] = '{1, 4, 5, 12, 13, 181, 182, 186};

   irq_source_model irq_source_model_i (.aclk(aclk), .aresetn(aresetn),
      .line_idx(line_idx), .raise(raise), .drop(drop),
      .l2_cache_irq(l2_cache_irq), .dma_irq(dma_irq),
      .periph_irq(periph_irq), .bus_error_irq(bus_error_irq));

   irq_source_priority_pending irq_source_priority_pending_i (.aclk(aclk),
      .aresetn(aresetn), .l2_cache_irq(l2_cache_irq), .dma_irq(dma_irq),
      .periph_irq(periph_irq), .bus_error_irq(bus_error_irq),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .irq_request(irq_request));

   // ---------------------------------------------------------------
   // Bus and compare tasks
   // ---------------------------------------------------------------
   function automatic logic [31:0] pa(input logic [31:0] base, input int n);
      return base + 32'(4 * n);
   endfunction : pa

   task automatic chk(input string name, input logic [31:0] exp, got);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bit aw_ok = 0;
      bit w_ok = 0;
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!(aw_ok && w_ok))
      begin
         @(posedge aclk);
         if (!aw_ok && awready === 1'b1)
         begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1)
         begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      rs = bresp;
   endtask : wr

   task automatic rdw(input logic [31:0] a);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rd = rdata;
      rs = rresp;
   endtask : rdw

   task automatic rd_chk(input string n, input logic [31:0] a, exp);
      rdw(a);
      chk(n, exp, rd);
   endtask : rd_chk

   task automatic chk_pend;
      for (int w = 0; w < 6; w++)
         rd_chk("pending", pa(irq_src_pkg::PEND_BASE, w), pend[w]);
   endtask : chk_pend

   task automatic set_line(input int idx, input logic lvl);
      line_idx <= 8'(idx);
      raise    <= lvl;
      drop     <= !lvl;
      @(posedge aclk);
      raise    <= 1'b0;
      drop     <= 1'b0;
      @(posedge aclk);
   endtask : set_line

   // Threshold write, then irq_request sampled once it has settled
   task automatic thr_irq(input logic [31:0] t, input logic exp);
      wr(irq_src_pkg::THR_ADDR, t);
      repeat (3) @(posedge aclk);
      chk("irq_request", {31'h0, exp}, {31'h0, irq_request});
   endtask : thr_irq

   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : test_done

   // ---------------------------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial
   begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   // Whole run needs well under a thousand cycles
   always @(posedge aclk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         test_done();
      end
   end

   initial
   begin
      {aresetn, raise, drop, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr, line_idx} = '0;
      wstrb = 4'hf;
      en = '{default: 32'h0};
      pend = '{default: 32'h0};
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      chk_pend();
      rd_chk("prio reset", pa(irq_src_pkg::PRIO_BASE, 1), 32'h0);
      rdw(irq_src_pkg::PRIO_BASE);
      chk("resp id0", 32'(irq_src_pkg::RESP_SLVERR), 32'(rs));
      rdw(pa(irq_src_pkg::PRIO_BASE, 187));
      chk("resp id187", 32'(irq_src_pkg::RESP_SLVERR), 32'(rs));
      wr(irq_src_pkg::PRIO_BASE, 32'h7);
      chk("bresp id0", 32'(irq_src_pkg::RESP_SLVERR), 32'(rs));
      wr(pa(irq_src_pkg::PRIO_BASE, 13), 32'hffff_fffe);
      chk("bresp", 32'(irq_src_pkg::RESP_OKAY), 32'(rs));
      rd_chk("prio", pa(irq_src_pkg::PRIO_BASE, 13), 32'h6);
      wr(irq_src_pkg::THR_ADDR, 32'hffff_fff5);
      rd_chk("threshold", irq_src_pkg::THR_ADDR, 32'h5);
      wr(irq_src_pkg::THR_ADDR, 32'h0);
      $display("test registers done");

      // First and last source of each group, so both ends of the range too
      foreach (ids[k])
      begin
         wr(pa(irq_src_pkg::PRIO_BASE, ids[k]), 32'h1);
         en[ids[k] / 32][ids[k] % 32] = 1'b1;
         pend[ids[k] / 32][ids[k] % 32] = 1'b1;
         set_line(ids[k] - 1, 1'b1);
      end
      for (int w = 0; w < 6; w++)
         wr(pa(irq_src_pkg::ENAB_BASE, w), en[w]);
      repeat (4) @(posedge aclk);
      chk_pend();
      wr(irq_src_pkg::PEND_BASE, 32'h0);
      rd_chk("pending ro", irq_src_pkg::PEND_BASE, pend[0]);
      foreach (ids[k])
      begin
         rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'(ids[k]));
         pend[ids[k] / 32][ids[k] % 32] = 1'b0;
      end
      rd_chk("claim none", irq_src_pkg::CLAIM_ADDR, 32'h0);
      chk_pend();
      for (int k = 0; k < 6; k++)
         set_line(ids[k] - 1, 1'b0);
      foreach (ids[k])
         wr(irq_src_pkg::CLAIM_ADDR, 32'(ids[k]));
      repeat (4) @(posedge aclk);
      // Lines of 182 and 186 are still high, so both flags return
      pend[5][22] = 1'b1;
      pend[5][26] = 1'b1;
      chk_pend();
      rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'd182);
      rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'd186);
      set_line(185, 1'b0);
      set_line(181, 1'b0);
      wr(irq_src_pkg::CLAIM_ADDR, 32'd186);
      wr(irq_src_pkg::CLAIM_ADDR, 32'd182);
      pend[5][22] = 1'b0;
      pend[5][26] = 1'b0;
      chk_pend();
      $display("test mapping and claim done");

      wr(pa(irq_src_pkg::PRIO_BASE, 13), 32'h3);
      wr(pa(irq_src_pkg::PRIO_BASE, 182), 32'h6);
      wr(pa(irq_src_pkg::PRIO_BASE, 5), 32'h0);
      set_line(4, 1'b1);
      set_line(12, 1'b1);
      set_line(181, 1'b1);
      thr_irq(32'h0, 1'b1);
      thr_irq(32'h6, 1'b0);
      thr_irq(32'h5, 1'b1);
      thr_irq(32'h7, 1'b0);
      wr(irq_src_pkg::THR_ADDR, 32'h0);
      rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'd182);
      rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'd13);
      rd_chk("claim", irq_src_pkg::CLAIM_ADDR, 32'h0);
      rd_chk("pending", irq_src_pkg::PEND_BASE, 32'h20);
      $display("test priority and threshold done");
      test_done();
   end
endmodule : irq_source_priority_pending_bench
